/* dv/flash_far_side.sv */
// host master and controller core stand-in on the mapper's far side
`timescale 1ns/1ps
module flash_far_side (
   input  wire logic        clk_sys,
   output      logic        host_req,
   output      logic        host_write,
   output      logic        host_fwh,
   output      logic [31:0] host_addr,
   output      logic [15:0] ec_code_addr,
   output      logic [7:0]  port_one_register
);
   initial begin
      host_req = 1'h0;
      host_write = 1'h0;
      host_fwh = 1'h0;
      host_addr = 32'h0;
      ec_code_addr = 16'h0;
      port_one_register = 8'h0;
   end
   // one host memory cycle, released right after the taking edge
   task automatic host_access(input logic [31:0] a, input logic w, f);
      @(posedge clk_sys);
      host_req <= 1'h1;
      host_write <= w;
      host_fwh <= f;
      host_addr <= a;
      @(posedge clk_sys);
      host_req <= 1'h0;
      host_addr <= ~a;
   endtask : host_access
   task automatic code_fetch(input logic [15:0] a);
      @(posedge clk_sys);
      ec_code_addr <= a;
      @(posedge clk_sys);
   endtask : code_fetch
   task automatic set_port(input logic [7:0] v);
      port_one_register <= v;
   endtask : set_port
endmodule : flash_far_side

/* dv/flash_map_asserts.sv */
// port-level assertions for the shared flash address mapper
`timescale 1ns/1ps
module flash_map_asserts
   import flash_map_pkg::*;
(
   input wire logic                clk_sys,
   input wire logic                rst_n,
   input wire logic                avs_read,
   input wire logic                avs_write,
   input wire logic                avs_waitrequest,
   input wire logic                host_req,
   input wire logic [31:0]         host_addr,
   input wire logic [FLASH_AW-1:0] host_flash_addr,
   input wire logic                host_hit,
   input wire logic                host_ok,
   input wire logic [15:0]         ec_code_addr,
   input wire logic [FLASH_AW-1:0] ec_flash_addr,
   input wire logic                scratch_data_sel,
   input wire logic                scratch_code_sel
);
   logic [31:0] host_q;
   logic [15:0] code_q;
   always_ff @(posedge clk_sys) begin
      host_q <= host_addr;
      code_q <= ec_code_addr;
   end
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence bus_taken;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence one_answer;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence
   bus_answer_a: assert property (bus_taken |=> one_answer)
      else $error("bus answer not a single cycle");
   code_low_a: assert property (
      !ec_code_addr[15] |=> ec_flash_addr == {6'h00, code_q})
      else $error("common code bank mapped wrong");
   code_bank_a: assert property (
      ec_code_addr[15] |=> ec_flash_addr[14:0] == code_q[14:0]
      && ec_flash_addr >= 22'h008000 && ec_flash_addr <= 22'h027FFF)
      else $error("banked code address out of place");
   scratch_one_a: assert property (
      scratch_data_sel != scratch_code_sel)
      else $error("scratch memory in both or no space");
   scratch_rst_a: assert property (
      $rose(rst_n) |-> scratch_data_sel && !scratch_code_sel)
      else $error("scratch memory not in data space after reset");
   top_region_a: assert property (
      host_req && host_addr[31:17] == 15'h7FFF |=>
      !host_hit || host_flash_addr[16:0] == host_q[16:0])
      else $error("top host region offset wrong");
   seg_f_a: assert property (
      host_req && host_addr[31:16] == 16'h000F |=>
      !host_hit || host_flash_addr[16:0] == {1'h1, host_q[15:0]})
      else $error("segment F not in top 64k");
   ok_hit_a: assert property (host_ok |-> host_hit)
      else $error("access allowed without a window hit");
   host_hold_a: assert property (
      !host_req |=> $stable(host_flash_addr) && $stable(host_hit)
      && $stable(host_ok))
      else $error("host result changed without a request");
endmodule : flash_map_asserts

/* dv/tb_top.sv */
// self-checking bench for the shared flash address mapper
`timescale 1ns/1ps
module tb_top;
   import flash_map_pkg::*;
   logic                clk_sys;
   logic                rst_n;
   logic [7:0]          avs_address;
   logic                avs_read;
   logic                avs_write;
   logic [31:0]         avs_writedata;
   logic [31:0]         avs_readdata;
   logic                avs_waitrequest;
   logic                host_req;
   logic                host_write;
   logic                host_fwh;
   logic [31:0]         host_addr;
   logic [FLASH_AW-1:0] host_flash_addr;
   logic                host_hit;
   logic                host_ok;
   logic [15:0]         ec_code_addr;
   logic [7:0]          port_one_register;
   logic [FLASH_AW-1:0] ec_flash_addr;
   logic                scratch_data_sel;
   logic                scratch_code_sel;
   logic [31:0]         rd;
   logic [31:0]         sz;
   int                  mismatches;
   int                  tests_run;
   int                  cycles;
   shared_flash_address_mapper i_shared_flash_address_mapper (
      .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .host_req(host_req), .host_write(host_write), .host_fwh(host_fwh),
      .host_addr(host_addr), .host_flash_addr(host_flash_addr),
      .host_hit(host_hit), .host_ok(host_ok), .ec_code_addr(ec_code_addr),
      .port_one_register(port_one_register), .ec_flash_addr(ec_flash_addr),
      .scratch_data_sel(scratch_data_sel),
      .scratch_code_sel(scratch_code_sel));
   flash_far_side i_flash_far_side (
      .clk_sys(clk_sys), .host_req(host_req), .host_write(host_write),
      .host_fwh(host_fwh), .host_addr(host_addr),
      .ec_code_addr(ec_code_addr), .port_one_register(port_one_register));
   initial clk_sys = 1'h0;
   always #25 clk_sys = ~clk_sys;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'h1;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
      avs_write <= 1'h0;
   endtask : bus_wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      avs_address <= a;
      avs_read <= 1'h1;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'h0);
      rd = avs_readdata;
      avs_read <= 1'h0;
      chk(rd, exp);
   endtask : rd_chk
   task automatic host_chk(input logic [31:0] a, input logic w, f, h, o,
                           input logic [31:0] fa);
      i_flash_far_side.host_access(a, w, f);
      @(negedge clk_sys);
      chk(host_hit, h);
      chk(host_ok, o);
      chk(host_flash_addr, fa);
   endtask : host_chk
   task automatic code_chk(input logic [15:0] a, input logic [31:0] fa);
      i_flash_far_side.code_fetch(a);
      @(negedge clk_sys);
      chk(ec_flash_addr, fa);
   endtask : code_chk
   task automatic done(input string n);
      $display("test %s done", n);
   endtask : done
   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : summarize
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         summarize();
      end
   end
   initial begin
      rst_n = 1'h0;
      avs_address = 8'h00;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_writedata = 32'h0;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'h1;
      @(negedge clk_sys);
      chk(scratch_data_sel, 1'h1);
      rd_chk(OFS_SHM_CTRL, 32'h3);
      rd_chk(OFS_SIZE_SEL, 32'h2);
      rd_chk(OFS_CLEAR, 32'h0);
      bus_wr(8'h80, 32'hFFFF_FFFF);
      rd_chk(8'h80, 32'h0);
      done("reset");
      for (int s = 0; s < 6; s++) begin
         sz = 32'h0002_0000 << s;
         bus_wr(OFS_SIZE_SEL, s);
         host_chk(32'hFFFF_FFF0, 1'h0, 1'h0, 1'h1, 1'h1, sz - 32'h10);
         host_chk(32'h0 - sz, 1'h0, 1'h0, 1'h1, 1'h1, 32'h0);
         host_chk(32'h8000 - sz, 1'h0, 1'h0, 1'h1, 1'h1, 32'h8000);
      end
      done("sizes");
      bus_wr(OFS_SIZE_SEL, 32'h2);
      host_chk(32'h000F_1234, 1'h0, 1'h0, 1'h1, 1'h1, 32'h7_1234);
      host_chk(32'h000E_0010, 1'h0, 1'h0, 1'h0, 1'h0, 32'h0);
      bus_wr(OFS_SHM_CTRL, 32'h7);
      host_chk(32'h000E_0010, 1'h0, 1'h0, 1'h1, 1'h1, 32'h6_0010);
      bus_wr(OFS_UW_BASE, 32'h2000_0000);
      bus_wr(OFS_UW_SIZE, 32'h1_0000);
      host_chk(32'h2000_0004, 1'h0, 1'h0, 1'h0, 1'h0, 32'h0);
      bus_wr(OFS_SHM_CTRL, 32'hB);
      host_chk(32'h2000_0004, 1'h0, 1'h0, 1'h1, 1'h1, 32'h7_0004);
      host_chk(32'h2001_0000, 1'h0, 1'h0, 1'h0, 1'h0, 32'h0);
      done("windows");
      bus_wr(OFS_SHM_CTRL, 32'h2);
      host_chk(32'hFFFF_FFF0, 1'h0, 1'h0, 1'h0, 1'h0, 32'h7_FFF0);
      host_chk(32'hFFFF_FFF0, 1'h0, 1'h1, 1'h1, 1'h1, 32'h7_FFF0);
      bus_wr(OFS_SHM_CTRL, 32'h1);
      host_chk(32'hFFFF_FFF0, 1'h0, 1'h1, 1'h0, 1'h0, 32'h7_FFF0);
      done("gating");
      bus_wr(OFS_CLEAR, 32'h1);
      host_chk(32'hFFF8_1000, 1'h1, 1'h0, 1'h1, 1'h0, 32'h1000);
      bus_wr(OFS_SHM_CTRL, 32'h11);
      host_chk(32'hFFF8_1000, 1'h1, 1'h0, 1'h1, 1'h1, 32'h1000);
      bus_wr(OFS_FINE_WP, 32'h1);
      host_chk(32'hFFF8_1000, 1'h1, 1'h0, 1'h1, 1'h0, 32'h1000);
      host_chk(32'hFFF8_2000, 1'h1, 1'h0, 1'h1, 1'h1, 32'h2000);
      bus_wr(OFS_COARSE_RP_L, 32'h4);
      host_chk(32'hFFFA_0000, 1'h0, 1'h0, 1'h1, 1'h0, 32'h2_0000);
      host_chk(32'hFFFB_0000, 1'h0, 1'h0, 1'h1, 1'h1, 32'h3_0000);
      bus_wr(OFS_BLK_COUNT, 32'hFFFF);
      rd_chk(OFS_BLK_COUNT, 32'h3);
      rd_chk(OFS_BLK_COUNT, 32'h0);
      rd_chk(OFS_EVENTS, 32'h3);
      bus_wr(OFS_EVENTS, 32'h1);
      rd_chk(OFS_EVENTS, 32'h2);
      bus_wr(OFS_EVENTS, 32'h0);
      rd_chk(OFS_EVENTS, 32'h2);
      done("protection");
      code_chk(16'h0000, 32'h0);
      code_chk(16'h7FFF, 32'h7FFF);
      for (int b = 0; b < 4; b++) begin
         bus_wr(OFS_BANK_SEL, b);
         code_chk(16'h8123, 32'h8000 * (b + 1) + 32'h123);
      end
      code_chk(16'hFFFF, 32'h2_7FFF);
      bus_wr(OFS_BANK_SEL, 32'h0);
      i_flash_far_side.set_port(8'hFE);
      bus_wr(OFS_PROG_CFG, 32'h1);
      code_chk(16'h8123, 32'h1_8123);
      host_chk(32'hFFF9_8123, 1'h0, 1'h0, 1'h1, 1'h1, 32'h1_8123);
      done("code");
      bus_wr(OFS_BUS_CFG, 32'h1);
      rd_chk(OFS_STATUS, 32'h0701_8123);
      @(negedge clk_sys);
      chk(scratch_code_sel, 1'h1);
      chk(scratch_data_sel, 1'h0);
      done("scratch");
      summarize();
   end
endmodule : tb_top
bind shared_flash_address_mapper flash_map_asserts i_flash_map_asserts (
   .clk_sys(clk_sys), .rst_n(rst_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .host_req(host_req), .host_addr(host_addr),
   .host_flash_addr(host_flash_addr), .host_hit(host_hit),
   .host_ok(host_ok), .ec_code_addr(ec_code_addr),
   .ec_flash_addr(ec_flash_addr), .scratch_data_sel(scratch_data_sel),
   .scratch_code_sel(scratch_code_sel));

/* hw/flash_map_pkg.sv */
// constants, register map and state type for the shared flash address mapper
package flash_map_pkg;
   localparam int FLASH_AW = 22;

   // register byte offsets
   localparam logic [7:0] OFS_SHM_CTRL    = 8'h00;
   localparam logic [7:0] OFS_SIZE_SEL    = 8'h04;
   localparam logic [7:0] OFS_UW_BASE     = 8'h08;
   localparam logic [7:0] OFS_UW_SIZE     = 8'h0C;
   localparam logic [7:0] OFS_BANK_SEL    = 8'h10;
   localparam logic [7:0] OFS_PROG_CFG    = 8'h14;
   localparam logic [7:0] OFS_BUS_CFG     = 8'h18;
   localparam logic [7:0] OFS_FINE_RP     = 8'h1C;
   localparam logic [7:0] OFS_FINE_WP     = 8'h20;
   localparam logic [7:0] OFS_COARSE_RP_L = 8'h24;
   localparam logic [7:0] OFS_COARSE_RP_H = 8'h28;
   localparam logic [7:0] OFS_COARSE_WP_L = 8'h2C;
   localparam logic [7:0] OFS_COARSE_WP_H = 8'h30;
   localparam logic [7:0] OFS_STATUS      = 8'h34;
   localparam logic [7:0] OFS_EVENTS      = 8'h38;
   localparam logic [7:0] OFS_BLK_COUNT   = 8'h3C;
   localparam logic [7:0] OFS_CLEAR       = 8'h40;

   // shared memory control bit positions
   localparam int CTL_LPC_MEM = 0;
   localparam int CTL_FWH     = 1;
   localparam int CTL_BIOSEXT = 2;
   localparam int CTL_USRWIN  = 3;
   localparam int CTL_HOST_WA = 4;

   // status and event bit positions
   localparam int ST_HIT    = 24;
   localparam int ST_OK     = 25;
   localparam int ST_SCR    = 26;
   localparam int EV_RD_BLK = 0;
   localparam int EV_WR_BLK = 1;
   localparam int CLR_ALL   = 0;

   // reset values
   localparam logic [4:0]  RST_SHM_CTRL = 5'h03;
   localparam logic [2:0]  RST_SIZE_SEL = 3'h2;

   // sizes and segments
   localparam logic [2:0]  SIZE_SEL_MAX  = 3'h5;
   localparam logic [22:0] MIN_FLASH     = 23'h020000;
   localparam logic [22:0] FLASH_SPAN    = 23'h400000;
   localparam logic [21:0] SEG_64K       = 22'h010000;
   localparam logic [21:0] SEG_128K      = 22'h020000;
   localparam logic [21:0] FINE_LIMIT    = 22'h020000;
   localparam logic [15:0] HOST_SEG_F    = 16'h000F;
   localparam logic [15:0] HOST_SEG_E    = 16'h000E;
   localparam logic [2:0]  BANK_STEP     = 3'h1;
   localparam logic [15:0] COUNT_MAX     = 16'hFFFF;
   localparam logic [15:0] COUNT_ONE     = 16'h0001;

   typedef struct packed {
      logic [4:0]          shm_ctrl;
      logic [2:0]          size_sel;
      logic [31:0]         uw_base;
      logic [22:0]         uw_size;
      logic [1:0]          bank_sel;
      logic                bank_source_override;
      logic                scratch_code;
      logic [15:0]         fine_rp;
      logic [15:0]         fine_wp;
      logic [63:0]         coarse_rp;
      logic [63:0]         coarse_wp;
      logic [1:0]          events;
      logic [15:0]         blk_count;
      logic                waitrequest;
      logic [31:0]         readdata;
      logic [FLASH_AW-1:0] host_flash_addr;
      logic                host_hit;
      logic                host_ok;
      logic [FLASH_AW-1:0] ec_flash_addr;
      logic                scratch_data_sel;
      logic                scratch_code_sel;
   } state_s;
endpackage : flash_map_pkg

/* hw/shared_flash_address_mapper.sv */
// host and controller address translation and host access protection for shared flash
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module shared_flash_address_mapper
   import flash_map_pkg::*;
(
   input  wire logic                clk_sys,
   input  wire logic                rst_n,
   input  wire logic [7:0]          avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   input  wire logic [3:0]          avs_byteenable,
   output      logic [31:0]         avs_readdata,
   output      logic                avs_waitrequest,
   input  wire logic                host_req,
   input  wire logic                host_write,
   input  wire logic                host_fwh,
   input  wire logic [31:0]         host_addr,
   output      logic [FLASH_AW-1:0] host_flash_addr,
   output      logic                host_hit,
   output      logic                host_ok,
   input  wire logic [15:0]         ec_code_addr,
   input  wire logic [7:0]          port_one_register,
   output      logic [FLASH_AW-1:0] ec_flash_addr,
   output      logic                scratch_data_sel,
   output      logic                scratch_code_sel
);

   state_s              s;
   state_s              next_s;

   logic [2:0]          size_sel_eff;
   logic [22:0]         flash_size;
   logic [21:0]         size_lo;
   logic                cyc_en;
   logic                top_hit;
   logic                user_hit;
   logic                f_hit;
   logic                e_hit;
   logic [31:0]         user_offs;
   logic [FLASH_AW-1:0] map_addr;
   logic                map_hit;
   logic                rp_bit;
   logic                wp_bit;
   logic                access_ok;
   logic [1:0]          bank;
   logic [31:0]         rd_mux;
   logic [31:0]         status_word;
   logic                bus_req;

   function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge_be

   // flash size and host window decode
   always_comb begin
      size_sel_eff = (s.size_sel > SIZE_SEL_MAX) ? SIZE_SEL_MAX : s.size_sel;
      flash_size   = MIN_FLASH << size_sel_eff;
      size_lo      = flash_size[21:0];
      cyc_en       = host_fwh ? s.shm_ctrl[CTL_FWH]
                              : s.shm_ctrl[CTL_LPC_MEM];
      top_hit      = (&host_addr[31:22])
                   && ({1'b0, host_addr[21:0]} >= (FLASH_SPAN - flash_size));
      user_offs    = host_addr - s.uw_base;
      user_hit     = s.shm_ctrl[CTL_USRWIN]
                   && (host_addr >= s.uw_base)
                   && (user_offs < {9'h000, s.uw_size})
                   && (s.uw_size <= flash_size);
      f_hit        = (host_addr[31:16] == HOST_SEG_F);
      e_hit        = (host_addr[31:16] == HOST_SEG_E)
                   && s.shm_ctrl[CTL_BIOSEXT];
      map_hit      = cyc_en && (top_hit || user_hit || f_hit || e_hit);
      // the top window spans all of flash, code region included; user and F windows end at the flash top, E ends 64k below it
      if (top_hit) begin
         map_addr = host_addr[21:0] + size_lo;
      end else if (user_hit) begin
         map_addr = size_lo - s.uw_size[21:0] + user_offs[21:0];
      end else if (f_hit) begin
         map_addr = size_lo - SEG_64K + {6'h00, host_addr[15:0]};
      end else if (e_hit) begin
         map_addr = size_lo - SEG_128K + {6'h00, host_addr[15:0]};
      end else begin
         map_addr = '0;
      end
   end

   // protection lookup on the translated address
   always_comb begin
      if (map_addr < FINE_LIMIT) begin
         rp_bit = s.fine_rp[map_addr[16:13]];
         wp_bit = s.fine_wp[map_addr[16:13]];
      end else begin
         rp_bit = s.coarse_rp[map_addr[21:16]];
         wp_bit = s.coarse_wp[map_addr[21:16]];
      end
      access_ok = map_hit && (host_write
                  ? (!wp_bit && s.shm_ctrl[CTL_HOST_WA])
                  : !rp_bit);
   end

   // controller code bank selection
   always_comb begin
      bank = s.bank_source_override ? port_one_register[1:0] : s.bank_sel;
   end

   // register read multiplexer
   always_comb begin
      status_word = '0;
      status_word[FLASH_AW-1:0] = s.host_flash_addr;
      status_word[ST_HIT]       = s.host_hit;
      status_word[ST_OK]        = s.host_ok;
      status_word[ST_SCR]       = s.scratch_code;
      if (avs_address == OFS_SHM_CTRL) begin
         rd_mux = {27'h0000000, s.shm_ctrl};
      end else if (avs_address == OFS_SIZE_SEL) begin
         rd_mux = {29'h00000000, s.size_sel};
      end else if (avs_address == OFS_UW_BASE) begin
         rd_mux = s.uw_base;
      end else if (avs_address == OFS_UW_SIZE) begin
         rd_mux = {9'h000, s.uw_size};
      end else if (avs_address == OFS_BANK_SEL) begin
         rd_mux = {30'h00000000, s.bank_sel};
      end else if (avs_address == OFS_PROG_CFG) begin
         rd_mux = {31'h00000000, s.bank_source_override};
      end else if (avs_address == OFS_BUS_CFG) begin
         rd_mux = {31'h00000000, s.scratch_code};
      end else if (avs_address == OFS_FINE_RP) begin
         rd_mux = {16'h0000, s.fine_rp};
      end else if (avs_address == OFS_FINE_WP) begin
         rd_mux = {16'h0000, s.fine_wp};
      end else if (avs_address == OFS_COARSE_RP_L) begin
         rd_mux = s.coarse_rp[31:0];
      end else if (avs_address == OFS_COARSE_RP_H) begin
         rd_mux = s.coarse_rp[63:32];
      end else if (avs_address == OFS_COARSE_WP_L) begin
         rd_mux = s.coarse_wp[31:0];
      end else if (avs_address == OFS_COARSE_WP_H) begin
         rd_mux = s.coarse_wp[63:32];
      end else if (avs_address == OFS_STATUS) begin
         rd_mux = status_word;
      end else if (avs_address == OFS_EVENTS) begin
         rd_mux = {30'h00000000, s.events};
      end else if (avs_address == OFS_BLK_COUNT) begin
         rd_mux = {16'h0000, s.blk_count};
      end else begin
         rd_mux = '0;
      end
   end

   // next state
   always_comb begin
      logic [31:0] wv;
      next_s  = s;
      wv      = '0;
      bus_req = avs_read || avs_write;
      // bus handshake: answer one cycle after the request is seen
      if (bus_req && s.waitrequest) begin
         next_s.waitrequest = 1'b0;
         next_s.readdata    = rd_mux;
      end else if (!s.waitrequest) begin
         next_s.waitrequest = 1'b1;
         next_s.readdata    = '0;
         if (avs_read && (avs_address == OFS_BLK_COUNT)) begin
            next_s.blk_count = '0;
         end
         if (avs_write) begin
            if (avs_address == OFS_SHM_CTRL) begin
               wv = merge_be({27'h0000000, s.shm_ctrl},
                             avs_writedata, avs_byteenable);
               next_s.shm_ctrl = wv[4:0];
            end else if (avs_address == OFS_SIZE_SEL) begin
               wv = merge_be({29'h00000000, s.size_sel},
                             avs_writedata, avs_byteenable);
               next_s.size_sel = wv[2:0];
            end else if (avs_address == OFS_UW_BASE) begin
               next_s.uw_base = merge_be(s.uw_base, avs_writedata,
                                         avs_byteenable);
            end else if (avs_address == OFS_UW_SIZE) begin
               wv = merge_be({9'h000, s.uw_size},
                             avs_writedata, avs_byteenable);
               next_s.uw_size = wv[22:0];
            end else if (avs_address == OFS_BANK_SEL) begin
               wv = merge_be({30'h00000000, s.bank_sel},
                             avs_writedata, avs_byteenable);
               next_s.bank_sel = wv[1:0];
            end else if (avs_address == OFS_PROG_CFG) begin
               wv = merge_be({31'h00000000, s.bank_source_override},
                             avs_writedata, avs_byteenable);
               next_s.bank_source_override = wv[0];
            end else if (avs_address == OFS_BUS_CFG) begin
               wv = merge_be({31'h00000000, s.scratch_code},
                             avs_writedata, avs_byteenable);
               next_s.scratch_code = wv[0];
            end else if (avs_address == OFS_FINE_RP) begin
               wv = merge_be({16'h0000, s.fine_rp},
                             avs_writedata, avs_byteenable);
               next_s.fine_rp = wv[15:0];
            end else if (avs_address == OFS_FINE_WP) begin
               wv = merge_be({16'h0000, s.fine_wp},
                             avs_writedata, avs_byteenable);
               next_s.fine_wp = wv[15:0];
            end else if (avs_address == OFS_COARSE_RP_L) begin
               next_s.coarse_rp[31:0] = merge_be(s.coarse_rp[31:0],
                                          avs_writedata, avs_byteenable);
            end else if (avs_address == OFS_COARSE_RP_H) begin
               next_s.coarse_rp[63:32] = merge_be(s.coarse_rp[63:32],
                                          avs_writedata, avs_byteenable);
            end else if (avs_address == OFS_COARSE_WP_L) begin
               next_s.coarse_wp[31:0] = merge_be(s.coarse_wp[31:0],
                                          avs_writedata, avs_byteenable);
            end else if (avs_address == OFS_COARSE_WP_H) begin
               next_s.coarse_wp[63:32] = merge_be(s.coarse_wp[63:32],
                                          avs_writedata, avs_byteenable);
            end else if (avs_address == OFS_EVENTS) begin
               if (avs_byteenable[0]) begin
                  next_s.events = s.events & ~avs_writedata[1:0];
               end
            end else if (avs_address == OFS_CLEAR) begin
               if (avs_byteenable[0] && avs_writedata[CLR_ALL]) begin
                  next_s.events    = '0;
                  next_s.blk_count = '0;
               end
            end
            // status and count words are read-only: writes are dropped
         end
      end
      // scratch placement follows its control bit exclusively
      next_s.scratch_code_sel = next_s.scratch_code;
      next_s.scratch_data_sel = !next_s.scratch_code;
      // host access result; a blocked access sets flags after any clear
      if (host_req) begin
         next_s.host_flash_addr = map_addr;
         next_s.host_hit        = map_hit;
         next_s.host_ok         = access_ok;
         if (map_hit && !access_ok) begin
            if (host_write) begin
               next_s.events[EV_WR_BLK] = 1'b1;
            end else begin
               next_s.events[EV_RD_BLK] = 1'b1;
            end
            if (next_s.blk_count != COUNT_MAX) begin
               next_s.blk_count = next_s.blk_count + COUNT_ONE;
            end
         end
      end
      // 64k code space: low half fixed, high half banked up to 160k
      if (ec_code_addr[15]) begin
         next_s.ec_flash_addr = {4'h0, ({1'b0, bank} + BANK_STEP),
                                 ec_code_addr[14:0]};
      end else begin
         next_s.ec_flash_addr = {6'h00, ec_code_addr};
      end
      // code lies in ordinary flash, so host windows reach it too
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s                  <= '0;
         s.shm_ctrl         <= RST_SHM_CTRL;
         s.size_sel         <= RST_SIZE_SEL;
         s.waitrequest      <= 1'b1;
         s.scratch_code     <= 1'b0;
         s.scratch_data_sel <= 1'b1;
         s.scratch_code_sel <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   assign avs_readdata     = s.readdata;
   assign avs_waitrequest  = s.waitrequest;
   assign host_flash_addr  = s.host_flash_addr;
   assign host_hit         = s.host_hit;
   assign host_ok          = s.host_ok;
   assign ec_flash_addr    = s.ec_flash_addr;
   assign scratch_data_sel = s.scratch_data_sel;
   assign scratch_code_sel = s.scratch_code_sel;

endmodule : shared_flash_address_mapper
